// [rtl/hpio_defines.svh]
`ifndef HPIO_DEFINES_SVH
`define HPIO_DEFINES_SVH
`define HPIO_ADDR_FOUR_MODE 8'h9C
`define HPIO_ADDR_FIVE_MODE 8'h9D
`define HPIO_ADDR_SIX_MODE 8'h9E
`define HPIO_ADDR_SEVEN_MODE 8'h9F
`define HPIO_ADDR_FOUR_LATCH 8'hC8
`define HPIO_ADDR_FIVE_LATCH 8'hD8
`define HPIO_ADDR_SIX_LATCH 8'hE8
`define HPIO_ADDR_SEVEN_LATCH 8'hF8
`define HPIO_PAGE_HIGH 8'h0F
`define HPIO_LATCH_RESET 8'hFF
`define HPIO_MODE_RESET 8'h00
`define HPIO_BIT_WR_STROBE 7
`define HPIO_BIT_RD_STROBE 6
`define HPIO_BIT_ADDR_LATCH 5
`endif

// [rtl/hpio_pkg.sv]
package hpio_pkg;
  typedef struct packed {
    logic active;
    logic is_read;
    logic multiplexed;
    logic wr_strobe_n;
    logic rd_strobe_n;
    logic addr_latch;
    logic [15:0] address;
    logic [7:0] wdata;
    logic addr_phase;
  } hpio_mem_t;
  typedef struct packed {
    logic [3:0][7:0] latch;
    logic [3:0][7:0] mode;
    logic [7:0] rdata;
  } hpio_state_t;
endpackage

// [rtl/hpio_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module hpio_sync #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // hpio_sync
`default_nettype wire

// [rtl/hpio_high_port.sv]
`include "hpio_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module hpio_high_port
  import hpio_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] register_page_select,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic pullup_global_disable,
  input wire logic ext_mem_on_high_ports,
  input wire hpio_mem_t ext_mem,
  output logic [7:0] ext_mem_rdata,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic [31:0] pin_pullup_en
);
  hpio_state_t state;
  hpio_state_t next_state;
  logic [31:0] pin_sync;
  logic [31:0] level;
  logic [31:0] mem_own;
  logic [31:0] mem_val;
  logic [31:0] data_release;
  logic mem_live;
  logic [31:0] want_oe;

  hpio_sync #(.WIDTH(32)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  function automatic int reg_index(input logic [7:0] addr, input logic [7:0] base0,
                                   input logic [7:0] base1, input logic [7:0] base2,
                                   input logic [7:0] base3);
    int idx;
    idx = -1;
    if (addr == base0) idx = 0;
    if (addr == base1) idx = 1;
    if (addr == base2) idx = 2;
    if (addr == base3) idx = 3;
    return idx;
  endfunction

  // Memory ownership and values per pin.
  always_comb begin
    mem_live = ext_mem_on_high_ports && ext_mem.active;
    mem_own = '0;
    mem_val = '0;
    data_release = '0;
    if (mem_live) begin
      mem_own[`HPIO_BIT_WR_STROBE] = 1'b1;
      mem_own[`HPIO_BIT_RD_STROBE] = 1'b1;
      mem_own[`HPIO_BIT_ADDR_LATCH] = 1'b1;
      mem_val[`HPIO_BIT_WR_STROBE] = ext_mem.wr_strobe_n;
      mem_val[`HPIO_BIT_RD_STROBE] = ext_mem.rd_strobe_n;
      mem_val[`HPIO_BIT_ADDR_LATCH] = ext_mem.addr_latch;
      mem_own[23:16] = 8'hFF;
      mem_own[31:24] = 8'hFF;
      if (ext_mem.multiplexed) begin
        mem_val[23:16] = ext_mem.address[15:8];
        mem_val[31:24] = ext_mem.addr_phase ? ext_mem.address[7:0] : ext_mem.wdata;
        if (ext_mem.is_read && !ext_mem.addr_phase) data_release[31:24] = 8'hFF;
      end else begin
        mem_own[15:8] = 8'hFF;
        mem_val[15:8] = ext_mem.address[15:8];
        mem_val[23:16] = ext_mem.address[7:0];
        mem_val[31:24] = ext_mem.wdata;
        if (ext_mem.is_read) data_release[31:24] = 8'hFF;
      end
    end
  end

  // Pin drive: memory values override latches, modes kept.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      level[i] = mem_own[i] ? mem_val[i] : state.latch[i/8][i%8];
      want_oe[i] = !level[i] || state.mode[i/8][i%8];
      pin_oe[i] = want_oe[i] && !data_release[i];
      pin_out[i] = level[i];
      pin_pullup_en[i] = !pullup_global_disable && !(pin_oe[i] && !level[i]);
    end
  end

  // Register bus: page and address decode, writes and registered reads.
  always_comb begin
    int li;
    int mi;
    li = reg_index(sfr_addr, `HPIO_ADDR_FOUR_LATCH, `HPIO_ADDR_FIVE_LATCH,
                   `HPIO_ADDR_SIX_LATCH, `HPIO_ADDR_SEVEN_LATCH);
    mi = reg_index(sfr_addr, `HPIO_ADDR_FOUR_MODE, `HPIO_ADDR_FIVE_MODE,
                   `HPIO_ADDR_SIX_MODE, `HPIO_ADDR_SEVEN_MODE);
    next_state = state;
    if (register_page_select == `HPIO_PAGE_HIGH) begin
      if (sfr_write) begin
        if (li >= 0) next_state.latch[li[1:0]] = sfr_wdata;
        if (mi >= 0) next_state.mode[mi[1:0]] = sfr_wdata;
      end
      if (sfr_read) begin
        next_state.rdata = 8'h00;
        if (li >= 0) begin
          next_state.rdata = sfr_rmw ? state.latch[li[1:0]] :
                             pin_sync[li[1:0]*8 +: 8];
        end
        if (mi >= 0) next_state.rdata = state.mode[mi[1:0]];
      end
    end
  end

  // Reset leaves every pin open-drain with its latch high, so only pins owned by an active memory interface can be driven.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state.latch <= {4{`HPIO_LATCH_RESET}};
      state.mode <= {4{`HPIO_MODE_RESET}};
      state.rdata <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // Port seven pins also feed the memory interface read data.
  assign sfr_rdata = state.rdata;
  assign ext_mem_rdata = pin_sync[31:24];

  // Checks on pin drive, pullups and the register bus.
  AST_LATCH_ZERO_DRIVES: assert property (@(posedge clk) disable iff (reset)
    (!mem_live && state.latch[0][0] == 1'b0) |-> (pin_oe[0] && !pin_out[0]))
    else $error("latch zero not driven low");
  AST_OPEN_DRAIN_FLOATS: assert property (@(posedge clk) disable iff (reset)
    (!mem_live && state.latch[1][3] && !state.mode[1][3]) |-> !pin_oe[11])
    else $error("open-drain one is driven");
  AST_PUSH_PULL_HIGH: assert property (@(posedge clk) disable iff (reset)
    (!mem_live && state.mode[2][1]) |-> pin_oe[17])
    else $error("push-pull pin released");
  AST_MEM_STROBE: assert property (@(posedge clk) disable iff (reset)
    mem_live |-> (pin_out[7] == ext_mem.wr_strobe_n && pin_out[6] == ext_mem.rd_strobe_n))
    else $error("strobe not on port four");
  AST_READ_RELEASE: assert property (@(posedge clk) disable iff (reset)
    (mem_live && ext_mem.is_read && !ext_mem.multiplexed) |-> pin_oe[31:24] == 8'h00)
    else $error("data bus driven during read");
  AST_NONMUX_ADDR: assert property (@(posedge clk) disable iff (reset)
    (mem_live && !ext_mem.multiplexed) |-> pin_out[15:8] == ext_mem.address[15:8])
    else $error("upper address missing on port five");
  AST_PIN_READ: assert property (@(posedge clk) disable iff (reset)
    (sfr_read && !sfr_rmw && sfr_addr == `HPIO_ADDR_SEVEN_LATCH
     && register_page_select == `HPIO_PAGE_HIGH) |=> sfr_rdata == $past(pin_sync[31:24]))
    else $error("pin read wrong");
  AST_RMW_READ: assert property (@(posedge clk) disable iff (reset)
    (sfr_read && sfr_rmw && sfr_addr == `HPIO_ADDR_FOUR_LATCH
     && register_page_select == `HPIO_PAGE_HIGH) |=> sfr_rdata == $past(state.latch[0]))
    else $error("rmw read wrong");
  AST_PULLUP_OFF: assert property (@(posedge clk) disable iff (reset)
    pullup_global_disable |-> pin_pullup_en == 32'h0000_0000)
    else $error("pullup not disabled");
  AST_LOW_NO_PULLUP: assert property (@(posedge clk) disable iff (reset)
    (pin_oe[0] && !pin_out[0]) |-> !pin_pullup_en[0])
    else $error("pullup left on a low pin");
  AST_PAGE_GUARD: assert property (@(posedge clk) disable iff (reset)
    (sfr_write && register_page_select != `HPIO_PAGE_HIGH)
    |=> state.latch == $past(state.latch))
    else $error("write taken on a foreign page");

  // Checks while the memory interface owns pins.
  AST_ALE_PIN: assert property (@(posedge clk) disable iff (reset)
    mem_live |-> pin_out[5] == ext_mem.addr_latch)
    else $error("address latch enable not on port four");
  AST_MUX_HIGH_ADDR: assert property (@(posedge clk) disable iff (reset)
    (mem_live && ext_mem.multiplexed) |-> pin_out[23:16] == ext_mem.address[15:8])
    else $error("upper address missing on port six");
  AST_NONMUX_LOW_ADDR: assert property (@(posedge clk) disable iff (reset)
    (mem_live && !ext_mem.multiplexed) |-> pin_out[23:16] == ext_mem.address[7:0])
    else $error("lower address missing on port six");
  AST_NONMUX_DATA: assert property (@(posedge clk) disable iff (reset)
    (mem_live && !ext_mem.multiplexed) |-> pin_out[31:24] == ext_mem.wdata)
    else $error("data byte missing on port seven");
  AST_MUX_AD_ADDR: assert property (@(posedge clk) disable iff (reset)
    (mem_live && ext_mem.multiplexed && ext_mem.addr_phase)
    |-> pin_out[31:24] == ext_mem.address[7:0])
    else $error("low address missing on port seven");
  AST_MUX_READ_RELEASE: assert property (@(posedge clk) disable iff (reset)
    (mem_live && ext_mem.multiplexed && ext_mem.is_read && !ext_mem.addr_phase)
    |-> pin_oe[31:24] == 8'h00)
    else $error("data bus driven during multiplexed read");
  AST_MODE_KEPT: assert property (@(posedge clk) disable iff (reset)
    (mem_live && state.mode[2][1]) |-> pin_oe[17])
    else $error("memory activity changed a drive mode");

  // Main scenarios that the bench should reach.
  COV_MEM_READ: cover property (@(posedge clk) disable iff (reset) mem_live && ext_mem.is_read);
  COV_MEM_MUX: cover property (@(posedge clk) disable iff (reset) mem_live && ext_mem.multiplexed);
  COV_WRITE: cover property (@(posedge clk) disable iff (reset)
    sfr_write && sfr_addr == `HPIO_ADDR_FIVE_MODE);
  COV_PULLUP_OFF: cover property (@(posedge clk) disable iff (reset)
    pullup_global_disable);
  COV_RMW_READ: cover property (@(posedge clk) disable iff (reset)
    sfr_read && sfr_rmw);
endmodule // hpio_high_port
`default_nettype wire

// [sim/hpio_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none
module hpio_pins_model (
  input wire logic clk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup_en,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  output logic [31:0] pin_in
);
  logic [31:0] float_pat = 32'h55555555;
  // A pin nobody holds wanders, so a stale value is never seen.
  always_ff @(posedge clk) begin
    float_pat <= ~float_pat;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup_en | float_pat));
endmodule // hpio_pins_model
`default_nettype wire

// [sim/tb_high_port_io_with_memory_override.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_high_port_io_with_memory_override;
  import hpio_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] page = 8'h0F;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rmw = 1'b0;
  logic pud = 1'b0;
  logic on_high = 1'b0;
  hpio_mem_t mem = '0;
  logic [7:0] rdata;
  logic [7:0] mrdata;
  logic [31:0] pin_in, pin_out, pin_oe, pin_pu;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] ext_val = 32'h0;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  hpio_high_port dut_u (.clk(clk), .reset(reset), .sfr_addr(addr),
    .register_page_select(page), .sfr_write(wr), .sfr_read(rd), .sfr_rmw(rmw),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .pullup_global_disable(pud),
    .ext_mem_on_high_ports(on_high), .ext_mem(mem), .ext_mem_rdata(mrdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pu));
  hpio_pins_model pins_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic m, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rmw = m;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    rmw = 1'b0;
    @(negedge clk);
    chk({24'h0, rdata}, {24'h0, exp});
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk(pin_oe, 32'h0);
    chk(pin_out, 32'hFFFFFFFF);
    chk(pin_pu, 32'hFFFFFFFF);
    rd_chk(8'h9C, 1'b0, 8'h00);
    rd_chk(8'h9F, 1'b0, 8'h00);
    wr_reg(8'hC8, 8'h00);
    chk(pin_oe, 32'h000000FF);
    chk(pin_out, 32'hFFFFFF00);
    chk(pin_pu, 32'hFFFFFF00);
    wr_reg(8'hC8, 8'h0F);
    wr_reg(8'h9C, 8'h03);
    chk(pin_oe, 32'h000000F3);
    chk(pin_out, 32'hFFFFFF0F);
    rd_chk(8'h9C, 1'b0, 8'h03);
    wr_reg(8'h9E, 8'h02);
    wr_reg(8'h9D, 8'h80);
    chk(pin_oe, 32'h000280F3);
    rd_chk(8'h9E, 1'b0, 8'h02);
    rd_chk(8'hC8, 1'b1, 8'h0F);
    ext_en = 32'hFF000000;
    ext_val = 32'h3C000000;
    repeat (3) @(negedge clk);
    rd_chk(8'hF8, 1'b0, 8'h3C);
    rd_chk(8'hF8, 1'b1, 8'hFF);
    chk({24'h0, mrdata}, 32'h3C);
    page = 8'h00;
    wr_reg(8'hE8, 8'h00);
    page = 8'h0F;
    wr_reg(8'hC9, 8'h00);
    chk(pin_oe, 32'h000280F3);
    rd_chk(8'hC9, 1'b0, 8'h00);
    pud = 1'b1;
    @(negedge clk);
    chk(pin_pu, 32'h0);
    pud = 1'b0;
    ext_en = 32'h0;
    on_high = 1'b1;
    mem = '{active: 1'b1, wr_strobe_n: 1'b0, rd_strobe_n: 1'b1, address: 16'h1234,
      wdata: 8'h5A, default: 1'b0};
    @(negedge clk);
    chk(pin_out, 32'h5A34124F);
    chk(pin_oe & 32'h000000FF, 32'h000000B3);
    mem.is_read = 1'b1;
    mem.rd_strobe_n = 1'b0;
    mem.wr_strobe_n = 1'b1;
    @(negedge clk);
    chk(pin_oe & 32'hFF000000, 32'h0);
    chk(pin_out & 32'h000000E0, 32'h00000080);
    mem.is_read = 1'b0;
    mem.multiplexed = 1'b1;
    mem.addr_phase = 1'b1;
    mem.addr_latch = 1'b1;
    @(negedge clk);
    chk(pin_out & 32'hFFFFFFE0, 32'h3412FFA0);
    mem.is_read = 1'b1;
    mem.addr_phase = 1'b0;
    mem.addr_latch = 1'b0;
    @(negedge clk);
    chk(pin_oe & 32'hFF000000, 32'h0);
    mem = '0;
    on_high = 1'b0;
    @(negedge clk);
    chk(pin_out, 32'hFFFFFF0F);
    finish_test();
  end
endmodule // tb_high_port_io_with_memory_override
`default_nettype wire
